// ===== verilog/baud_gen.sv
// Purpose: baud rate generator with auto-baud measurement of a 55h sync byte
// Assumes: 200 MHz clock; receive line asynchronous; shift logic lives elsewhere
// Notes: registers sit on a plain port with read data one cycle after the strobe
//
// How it works
// - rate is osc over 64, 16 or 4 times n+1
// - synchronous mode ignores high speed, divides by 4(n+1)
// - in auto-baud the receive line times the counter
// - measure 55h sync over its five rising edges
// - enable starts calibration, receiver held idle
// - counting starts at first rise after start bit
// - fifth rise stops, clears enable, sets receive flag
// - both divisor bytes form one 16-bit counter
// - counter runs at one eighth of base clock
// - counter clock is osc over 512, 128 or 32
// - counter starts at one; software subtracts one
// - with wake enable, detect the byte after break
// - divisor write resets the baud timer at once
// - default 8-bit, wide select gives 16-bit divisor
// - overflow sets sticky flag, counting continues
`timescale 1ns/100ps
module baud_gen (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_rx,
  input wire logic i_rx_busy,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_done,
  output logic o_baud_tick,
  output logic o_rx_hold_idle,
  output logic o_rx_flag,
  output logic [7:0] o_tx_ctrl,
  output logic [7:0] o_rx_ctrl
);
  import baud_pkg::*;

  // ***********************************************
  // registers
  // ***********************************************
  logic [7:0] tx_ctrl_q;
  logic [7:0] rx_ctrl_q;
  logic [7:0] div_high_q;
  logic [7:0] div_low_q;
  logic wide_q;
  logic wake_q;
  logic abd_en_q;
  logic ovf_q;
  logic rx_flag_q;
  logic [7:0] rx_data_q;
  logic [7:0] rdata_q;
  abd_state_t state_q;
  logic [2:0] edges_q;

  logic sync_mode;
  logic high_speed;
  logic wr_high;
  logic wr_low;
  logic wr_bc;
  logic rd_data;
  logic rx_level;
  logic rx_rise;
  logic rx_fall;
  logic measuring;
  logic abd_done;
  logic base_tick;
  logic abd_tick;
  logic [15:0] limit;
  logic [15:0] pair;
  logic [16:0] pair_inc;

  assign sync_mode = tx_ctrl_q[TX_SYNC_BIT];
  assign high_speed = tx_ctrl_q[TX_HIGH_SPEED_BIT];
  assign wr_high = i_wr && (i_addr == ADDR_DIV_HIGH);
  assign wr_low = i_wr && (i_addr == ADDR_DIV_LOW);
  assign wr_bc = i_wr && (i_addr == ADDR_BAUD_CTRL);
  assign rd_data = i_rd && (i_addr == ADDR_RX_DATA);
  assign pair = {div_high_q, div_low_q};
  assign pair_inc = {1'b0, pair} + 17'h00001;
  assign measuring = (state_q == ABD_COUNT);

  // ***********************************************
  // receive line synchroniser
  // ***********************************************
  line_sync u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_line(i_rx),
    .o_level(rx_level),
    .o_rise(rx_rise),
    .o_fall(rx_fall)
  );

  // ***********************************************
  // base clock prescaler
  // ***********************************************
  // prescale counts up to the largest figure; a 9-bit count covers 512
  localparam int PRE_W = 9;
  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] pre_last;
  logic [PRE_W-1:0] pre_base;

  always_comb begin
    if (sync_mode || (wide_q && high_speed)) begin
      pre_base = PRE_W'(PRE_FAST);
    end else if (wide_q || high_speed) begin
      pre_base = PRE_W'(PRE_MID);
    end else begin
      pre_base = PRE_W'(PRE_SLOW);
    end
    // auto-baud runs eight times slower: 512, 128 or 32
    if (abd_en_q) begin
      pre_last = PRE_W'(pre_base * PRE_W'(ABD_SLOWDOWN) - 1'b1);
    end else begin
      pre_last = PRE_W'(pre_base - 1'b1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || wr_high || wr_low || wr_bc) begin
      pre_q <= '0;
    end else if (pre_q >= pre_last) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  assign base_tick = !abd_en_q && (pre_q >= pre_last);
  assign abd_tick = abd_en_q && (pre_q >= pre_last);

  // ***********************************************
  // free-running baud timer
  // ***********************************************
  // 8-bit mode looks only at the low byte
  assign limit = wide_q ? pair : {8'h00, div_low_q};

  tick_divider #(
    .WIDTH(16)
  ) u_div (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clear(wr_high || wr_low),
    .i_tick(base_tick),
    .i_limit(limit),
    .o_tick(o_baud_tick)
  );

  // ***********************************************
  // auto-baud sequencer
  // ***********************************************
  // a rise while still in wait-start means the line was idle-low (break);
  // with wake enabled the break's fall is skipped; its end rise clears wake, then the real start bit
  assign abd_done = measuring && rx_rise && (edges_q == ABD_EDGES - 3'h1);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !abd_en_q) begin
      state_q <= ABD_IDLE;
      edges_q <= '0;
    end else begin
      unique case (state_q)
        ABD_IDLE: begin
          state_q <= ABD_WAIT_START;
        end
        ABD_WAIT_START: begin
          if (rx_fall && !(wake_q && !rx_level)) begin
            state_q <= ABD_WAIT_EDGE;
          end
        end
        ABD_WAIT_EDGE: begin
          if (rx_rise) begin
            state_q <= ABD_COUNT;
            edges_q <= 3'h1;
          end
        end
        ABD_COUNT: begin
          if (rx_rise) begin
            edges_q <= edges_q + 3'h1;
          end
        end
      endcase
    end
  end

  assign o_rx_hold_idle = abd_en_q || wake_q;

  // ***********************************************
  // control and divisor registers
  // ***********************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_ctrl_q <= TX_CTRL_RST;
      rx_ctrl_q <= RX_CTRL_RST;
    end else if (i_wr && i_addr == ADDR_TX_CTRL) begin
      tx_ctrl_q <= i_wdata;
    end else if (i_wr && i_addr == ADDR_RX_CTRL) begin
      rx_ctrl_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      div_high_q <= DIV_RST;
      div_low_q <= DIV_RST;
    end else if (state_q == ABD_WAIT_EDGE && rx_rise) begin
      {div_high_q, div_low_q} <= ABD_START;
    end else if (measuring && abd_tick && !abd_done) begin
      {div_high_q, div_low_q} <= pair_inc[15:0];
    end else if (wr_high) begin
      div_high_q <= i_wdata;
    end else if (wr_low) begin
      div_low_q <= i_wdata;
    end
  end

  // hardware set of the overflow flag beats a software clear
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wide_q <= BAUD_CTRL_RST[BC_WIDE_BIT];
      wake_q <= BAUD_CTRL_RST[BC_WAKE_BIT];
      abd_en_q <= BAUD_CTRL_RST[BC_ABD_BIT];
      ovf_q <= BAUD_CTRL_RST[BC_OVF_BIT];
    end else begin
      if (wr_bc) begin
        wide_q <= i_wdata[BC_WIDE_BIT];
        wake_q <= i_wdata[BC_WAKE_BIT];
        abd_en_q <= i_wdata[BC_ABD_BIT];
      end
      if (abd_done) begin
        abd_en_q <= 1'b0;
      end
      if (wake_q && abd_en_q && state_q == ABD_WAIT_START && rx_rise) begin
        wake_q <= 1'b0;
      end
      if (measuring && abd_tick && !abd_done && pair_inc[16]) begin
        ovf_q <= 1'b1;
      end else if (wr_bc && !i_wdata[BC_OVF_BIT] && !abd_en_q) begin
        ovf_q <= 1'b0;
      end
    end
  end

  // ***********************************************
  // receive flag and data
  // ***********************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_flag_q <= 1'b0;
      rx_data_q <= '0;
    end else if (abd_done || i_rx_done) begin
      rx_flag_q <= 1'b1;
      if (i_rx_done) begin
        rx_data_q <= i_rx_data;
      end
    end else if (rd_data) begin
      rx_flag_q <= 1'b0;
    end
  end

  // ***********************************************
  // read port
  // ***********************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_q <= '0;
    end else if (i_rd) begin
      unique case (i_addr)
        ADDR_TX_CTRL: rdata_q <= tx_ctrl_q;
        ADDR_RX_CTRL: rdata_q <= rx_ctrl_q;
        ADDR_BAUD_CTRL: rdata_q <= {ovf_q, ~i_rx_busy, 2'b00, wide_q, 1'b0, wake_q, abd_en_q};
        ADDR_DIV_HIGH: rdata_q <= div_high_q;
        ADDR_DIV_LOW: rdata_q <= div_low_q;
        ADDR_RX_DATA: rdata_q <= rx_data_q;
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign o_rdata = rdata_q;
  assign o_rx_flag = rx_flag_q;
  assign o_tx_ctrl = tx_ctrl_q;
  assign o_rx_ctrl = rx_ctrl_q;
endmodule

// ===== verilog/baud_pkg.sv
// Purpose: shared constants of the baud generator with auto-baud detection
// Assumes: one 200 MHz system clock, plain register port
// Notes: offsets are word indices on the plain register port
package baud_pkg;
  // ***********************************************
  // register offsets
  // ***********************************************
  localparam logic [2:0] ADDR_TX_CTRL = 3'h0;
  localparam logic [2:0] ADDR_RX_CTRL = 3'h1;
  localparam logic [2:0] ADDR_BAUD_CTRL = 3'h2;
  localparam logic [2:0] ADDR_DIV_HIGH = 3'h3;
  localparam logic [2:0] ADDR_DIV_LOW = 3'h4;
  localparam logic [2:0] ADDR_RX_DATA = 3'h5;
  // ***********************************************
  // field positions
  // ***********************************************
  localparam int TX_SYNC_BIT = 4;
  localparam int TX_HIGH_SPEED_BIT = 2;
  localparam int BC_OVF_BIT = 7;
  localparam int BC_IDLE_BIT = 6;
  localparam int BC_WIDE_BIT = 3;
  localparam int BC_WAKE_BIT = 1;
  localparam int BC_ABD_BIT = 0;
  // ***********************************************
  // reset values
  // ***********************************************
  localparam logic [7:0] TX_CTRL_RST = 8'h02;
  localparam logic [7:0] RX_CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_CTRL_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [7:0] BC_WRITE_MASK = 8'h3B;
  // ***********************************************
  // base clock prescales, in oscillator cycles
  // ***********************************************
  localparam int PRE_SLOW = 64;
  localparam int PRE_MID = 16;
  localparam int PRE_FAST = 4;
  localparam int ABD_SLOWDOWN = 8;
  localparam logic [15:0] ABD_START = 16'h0001;
  localparam logic [2:0] ABD_EDGES = 3'h5;
  typedef enum logic [1:0] {
    ABD_IDLE = 2'b00,
    ABD_WAIT_START = 2'b01,
    ABD_WAIT_EDGE = 2'b11,
    ABD_COUNT = 2'b10
  } abd_state_t;
endpackage

// ===== verilog/line_sync.sv
// Purpose: two-stage synchroniser with rising-edge pulse
// Assumes: input is asynchronous to i_clk
// Notes: the first stage feeds only the second
`timescale 1ns/100ps
module line_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_line,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= i_line;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_rise = sync_q & ~prev_q;
  assign o_fall = ~sync_q & prev_q;
endmodule

// ===== verilog/tick_divider.sv
// Purpose: programmable divider giving a one-cycle enable every n+1 input ticks
// Assumes: i_tick is a one-cycle enable on i_clk
// Notes: i_clear restarts the count at once
`timescale 1ns/100ps
module tick_divider #(
  parameter int WIDTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clear,
  input wire logic i_tick,
  input wire logic [WIDTH-1:0] i_limit,
  output logic o_tick
);
  logic [WIDTH-1:0] count_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_clear) begin
      count_q <= '0;
    end else if (i_tick) begin
      if (count_q >= i_limit) begin
        count_q <= '0;
      end else begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  assign o_tick = i_tick && (count_q >= i_limit);
endmodule

// ===== verification/baud_gen_checker.sv
// Purpose: port-level checks of the baud generator
// Assumes: one clock, synchronous active-low reset
// Notes: bound to baud_gen from the bench top file
`timescale 1ns/100ps
module baud_gen_checker
  import baud_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_rx,
  input wire logic i_rx_busy,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_done,
  input wire logic o_baud_tick,
  input wire logic o_rx_hold_idle,
  input wire logic o_rx_flag,
  input wire logic [7:0] o_tx_ctrl,
  input wire logic [7:0] o_rx_ctrl
);
  // ********************************
  // port relations
  // ********************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  AST_HS_SEL: assert property (i_wr && i_addr == ADDR_TX_CTRL
    |=> (o_tx_ctrl & 8'h04) == ($past(i_wdata) & 8'h04)) else $error("speed select lost");
  AST_SYNC_SEL: assert property (i_wr && i_addr == ADDR_TX_CTRL
    |=> (o_tx_ctrl & 8'h10) == ($past(i_wdata) & 8'h10)) else $error("sync select lost");
  AST_HOLD_SET: assert property (i_wr && i_addr == ADDR_BAUD_CTRL && i_wdata[BC_ABD_BIT]
    |=> o_rx_hold_idle) else $error("receiver not held idle");
  AST_DONE_FLAG: assert property ($fell(o_rx_hold_idle) && !$past(i_wr)
    |-> o_rx_flag) else $error("calibration end without receive flag");
  AST_FLAG_CLR: assert property (i_rd && i_addr == ADDR_RX_DATA && !i_rx_done
    && !o_rx_hold_idle |=> !o_rx_flag) else $error("receive flag not cleared by read");
  AST_DIV_RESTART: assert property (i_wr && (i_addr == ADDR_DIV_LOW
    || i_addr == ADDR_DIV_HIGH) |=> !o_baud_tick [*2]) else $error("timer not restarted");
  AST_TICK_GAP: assert property (o_baud_tick |=> !o_baud_tick [*3])
    else $error("ticks closer than four clocks");
  AST_RX_SYNC: assert property ($rose(i_rx) |-> !$fell(o_rx_hold_idle) [*2])
    else $error("receive edge used before synchronising");
endmodule

// ===== verification/sync_sender.sv
// Purpose: remote transmitter sending one 55h sync byte
// Assumes: bit time given in system clocks
// Notes: optional all-zero break ahead of the sync byte
`timescale 1ns/100ps
module sync_sender (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [15:0] i_bit_cycles,
  input wire logic [15:0] i_break_cycles,
  output logic o_line
);
  // ********************************
  // frame driver
  // ********************************
  logic [8:0] frame_q;
  // one process owns the line, so it has a single driver
  initial begin
    o_line = 1'h1;
    forever begin
      @(posedge i_clk);
      if (i_go) begin
        frame_q = {8'h55, 1'h0};
        if (i_break_cycles != 16'h0000) begin
          o_line <= 1'h0;
          repeat (i_break_cycles) @(posedge i_clk);
          o_line <= 1'h1;
          repeat (i_bit_cycles) @(posedge i_clk);
        end
        for (int i = 0; i < 9; i++) begin
          o_line <= frame_q[i];
          repeat (i_bit_cycles) @(posedge i_clk);
        end
        // stop edge only; line then idles high so the next request is not missed
        o_line <= 1'h1;
      end
    end
  end
endmodule

// ===== verification/uart_baud_gen_autobaud_test.sv
// Purpose: self-checking bench for the baud generator
// Assumes: 200 MHz clock, sync sender drives the receive line
// Notes: auto-baud counts allow one count of phase slack
`timescale 1ns/100ps
module uart_baud_gen_autobaud_test;
  import baud_pkg::*;
  logic i_clk, i_rst_n, i_wr, i_rd, i_rx, i_rx_busy, i_rx_done, go;
  logic o_baud_tick, o_rx_hold_idle, o_rx_flag;
  logic [2:0] i_addr;
  logic [7:0] i_wdata, i_rx_data, o_rdata, o_tx_ctrl, o_rx_ctrl, rd_val, lo, hi, dat;
  logic [15:0] bitc, brk;
  int num_errors, compares, per, e, seed;
  bit s, w, h;
  baud_gen dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx(i_rx), .i_rx_busy(i_rx_busy),
    .i_rx_data(i_rx_data), .i_rx_done(i_rx_done), .o_baud_tick(o_baud_tick),
    .o_rx_hold_idle(o_rx_hold_idle), .o_rx_flag(o_rx_flag), .o_tx_ctrl(o_tx_ctrl),
    .o_rx_ctrl(o_rx_ctrl));
  sync_sender partner (.i_clk(i_clk), .i_go(go), .i_bit_cycles(bitc),
    .i_break_cycles(brk), .o_line(i_rx));
  // ********************************
  // helpers
  // ********************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'h0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge i_clk);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'h0;
    #1 rd_val = o_rdata;
  endtask
  function automatic int pre(input bit sy, input bit wi, input bit hs);
    return (sy || (wi && hs)) ? PRE_FAST : (wi ^ hs) ? PRE_MID : PRE_SLOW;
  endfunction
  // tick is combinational, so it is sampled at the falling edge
  task automatic period();
    int k;
    k = 0;
    per = 0;
    do begin
      @(negedge i_clk);
      k++;
    end while (o_baud_tick !== 1'h1 && k < 20000);
    do begin
      @(negedge i_clk);
      per++;
    end while (o_baud_tick !== 1'h1 && per < 20000);
  endtask
  task automatic abd(input bit wk, input int r);
    e = pre(1'h0, w, h) * ABD_SLOWDOWN;
    bitc <= 16'(e * r);
    brk <= wk ? 16'(e * r * 13) : 16'h0000;
    wr(ADDR_TX_CTRL, {5'h00, h, 2'h0});
    wr(ADDR_BAUD_CTRL, {4'h0, w, 1'h0, wk, 1'h1});
    #1 chk(16'(o_rx_hold_idle), 16'h0001);
    @(posedge i_clk) go <= 1'h1;
    @(posedge i_clk) go <= 1'h0;
    per = 0;
    while (o_rx_flag !== 1'h1 && per < 40000) begin
      @(negedge i_clk);
      per++;
    end
    e = 1 + 8 * r;
    chk(16'(o_rx_hold_idle), 16'h0000);
    rd(ADDR_DIV_LOW);
    chk((rd_val + 1 == e || rd_val == e + 1) ? 16'(e) : 16'(rd_val), 16'(e));
    rd(ADDR_DIV_HIGH);
    chk(16'(rd_val), 16'h0000);
    rd(ADDR_BAUD_CTRL);
    chk(16'(rd_val & 8'h03), 16'h0000);
    chk(16'(o_rx_flag), 16'h0001);
    rd(ADDR_RX_DATA);
    chk(16'(o_rx_flag), 16'h0000);
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ********************************
  // clock, watchdog, sequence
  // ********************************
  initial begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    repeat (60000) @(posedge i_clk);
    num_errors++;
    complete_run();
  end
  initial begin
    {i_rst_n, i_wr, i_rd, i_rx_busy, i_rx_done, go} = 6'h00;
    {i_addr, i_wdata, i_rx_data, bitc, brk} = 51'h0;
    num_errors = 0;
    compares = 0;
    seed = $urandom(32'ha5834bf0);
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'h1;
    for (int a = 0; a < 8; a++) begin
      if (a != 5) begin
        rd(3'(a));
        chk(16'(rd_val), a == 0 ? 16'(TX_CTRL_RST) : a == 1 ? 16'(RX_CTRL_RST) :
          a == 2 ? 16'(BAUD_CTRL_RST | 8'h40) : a < 5 ? 16'(DIV_RST) : 16'h0000);
      end
    end
    for (int m = 0; m < 6; m++) begin
      s = m[2];
      w = s ? m[0] : m[1];
      h = s ^ m[0];
      lo = 8'($urandom_range(15, 0));
      hi = 8'($urandom_range(1, 0));
      wr(ADDR_TX_CTRL, {3'h0, s, 1'h0, h, 2'h0});
      wr(ADDR_BAUD_CTRL, {4'h0, w, 3'h0});
      wr(ADDR_DIV_HIGH, hi);
      wr(ADDR_DIV_LOW, lo);
      period();
      chk(16'(per), 16'(pre(s, w, h) * ((w ? {hi, lo} : lo) + 1)));
    end
    dat = 8'($urandom);
    @(posedge i_clk) i_rx_data <= dat;
    i_rx_done <= 1'h1;
    @(posedge i_clk) i_rx_done <= 1'h0;
    rd(ADDR_RX_DATA);
    chk(16'(rd_val), 16'(dat));
    lo = 8'($urandom);
    wr(ADDR_RX_CTRL, lo);
    #1 chk(16'(o_rx_ctrl), 16'(lo));
    rd(ADDR_RX_CTRL);
    chk(16'(rd_val), 16'(lo));
    @(posedge i_clk) i_rx_busy <= 1'h1;
    rd(ADDR_BAUD_CTRL);
    chk(16'(rd_val & 8'h40), 16'h0000);
    @(posedge i_clk) i_rx_busy <= 1'h0;
    for (int m = 0; m < 4; m++) begin
      w = m[1];
      h = m[0];
      abd(1'h0, 1 + m[0]);
    end
    w = 1'h1;
    h = 1'h0;
    abd(1'h1, 1);
    // abort: enable cleared first, then the overflow flag
    wr(ADDR_BAUD_CTRL, 8'h01);
    wr(ADDR_BAUD_CTRL, 8'h00);
    wr(ADDR_BAUD_CTRL, 8'h00);
    rd(ADDR_BAUD_CTRL);
    chk(16'(rd_val & 8'h81), 16'h0000);
    chk(16'(o_rx_hold_idle), 16'h0000);
    complete_run();
  end
endmodule
bind baud_gen baud_gen_checker chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx(i_rx),
  .i_rx_busy(i_rx_busy), .i_rx_data(i_rx_data), .i_rx_done(i_rx_done),
  .o_baud_tick(o_baud_tick), .o_rx_hold_idle(o_rx_hold_idle), .o_rx_flag(o_rx_flag),
  .o_tx_ctrl(o_tx_ctrl), .o_rx_ctrl(o_rx_ctrl));
